// ===== hw/dsm_pkg.sv
// Purpose: Shared constants and types for the display scan-mode controller.
// Assumes: 200 MHz core clock, synchronous active-high reset.
// Notes: Times are held in their own unit and converted to cycles here.
package dsm_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int MS_PER_S = 1000;
    localparam int DEB_MS = 10;
    localparam int HOLD_S = 5;
    localparam int TICK_CYC = CLK_HZ;
    localparam int DEB_CYC = CLK_HZ / MS_PER_S * DEB_MS;
    localparam int HOLD_CYC = CLK_HZ * HOLD_S;
    localparam logic [8:0] PROMPT_S = 9'h001;
    localparam logic [8:0] POWERUP_S = 9'h03C;
    localparam logic [8:0] MAN_TO_S = 9'h12C;
    localparam logic [8:0] MAN_TO_PRIM_S = 9'h0B4;
    localparam int NPAR = 17;
    localparam int PW = 5;
    localparam logic [PW-1:0] P_BUS = 5'h00;
    localparam logic [PW-1:0] P_FUEL = 5'h10;
    // Exhaust/head per cylinder, turbine inlet and oil
    localparam logic [NPAR-1:0] LOCK_MASK = 17'h07F80;
    // First cylinder slot stands for the highest head temp
    localparam logic [NPAR-1:0] PRIM_MASK = 17'h06080;
    localparam logic [NPAR-1:0] ALL_MASK = 17'h1FFFF;
    localparam logic [7:0] CFG_ADDR = 8'h00;
    localparam logic [7:0] OPT_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [7:0] INCL_ADDR = 8'h0C;
    localparam logic [7:0] USED_ADDR = 8'h10;
    localparam logic [7:0] FOB_ADDR = 8'h14;
    localparam logic [7:0] ADD_ADDR = 8'h18;
    localparam logic [3:0] DWELL_DEF = 4'h4;
    localparam int CFG_ACC = 4;
    localparam int CFG_PRIM = 5;
    localparam int CFG_AUX = 6;
    localparam int CFG_TABS = 7;
    localparam logic [31:0] FULL_MAIN = 32'h000186A0;
    localparam logic [31:0] FULL_TOTAL = 32'h00030D40;
    localparam logic [31:0] ADD_STEP = 32'h000003E8;
    typedef enum logic [5:0] {
        ST_PROMPT = 6'h01,
        ST_CHOOSE = 6'h02,
        ST_CUSTOM = 6'h04,
        ST_MANUAL = 6'h08,
        ST_AUTO = 6'h10,
        ST_PRIM = 6'h20
    } dsm_state_t;
    typedef enum logic [1:0] {
        CH_NONE = 2'h0,
        CH_MAIN = 2'h1,
        CH_FULL = 2'h2,
        CH_CUSTOM = 2'h3
    } dsm_choice_t;
endpackage : dsm_pkg

// ===== hw/dsm_next_param.sv
// Purpose: Finds the next eligible parameter after the current one, wrapping.
// Assumes: Eligibility mask is one bit per parameter slot.
// Notes: Purely combinational; found is low when no slot is eligible.
`timescale 1ns/1ps
module dsm_next_param
    import dsm_pkg::*;
(
    input wire logic [PW-1:0] cur,
    input wire logic [NPAR-1:0] elig,
    output logic [PW-1:0] nxt,
    output logic found
);
    always_comb begin
        int j;
        j = 0;
        nxt = cur;
        found = 1'b0;
        // Walk backwards so the nearest eligible slot wins
        for (int k = NPAR; k >= 1; k--) begin
            j = (int'(cur) + k) % NPAR;
            if (elig[j]) begin
                nxt = PW'(j);
                found = 1'b1;
            end
        end
    end
endmodule : dsm_next_param

// ===== hw/dsm_buttons.sv
// Purpose: Synchronises, debounces and classifies the two panel buttons.
// Assumes: Raw button levels are active high.
// Notes: One press session yields at most one event; overlapping presses count as both.
`timescale 1ns/1ps
module dsm_buttons
    import dsm_pkg::*;
#(
    parameter int DEB = DEB_CYC,
    parameter int HOLD = HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic stepRaw,
    input wire logic leanRaw,
    output logic stepTap,
    output logic leanTap,
    output logic bothTap,
    output logic bothHold,
    output logic leanHeld
);
    logic [1:0] sync1_r, sync2_r, clean_r, seen_r;
    logic [31:0] deb_r [2];
    logic [31:0] hcnt_r;
    logic held_r;
    logic anyDown;

    assign anyDown = |clean_r;

    always_ff @(posedge core_clk) begin
        sync1_r <= {leanRaw, stepRaw};
        sync2_r <= sync1_r;
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset || sync2_r[i] == clean_r[i]) begin
                deb_r[i] <= 32'h0;
            end else if (deb_r[i] == 32'(DEB - 1)) begin
                deb_r[i] <= 32'h0;
            end else begin
                deb_r[i] <= deb_r[i] + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset) begin
                clean_r[i] <= 1'b0;
            end else if (sync2_r[i] != clean_r[i] && deb_r[i] == 32'(DEB - 1)) begin
                clean_r[i] <= sync2_r[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        stepTap <= 1'b0;
        leanTap <= 1'b0;
        bothTap <= 1'b0;
        bothHold <= 1'b0;
        if (reset) begin
            seen_r <= 2'h0;
            held_r <= 1'b0;
            hcnt_r <= 32'h0;
        end else if (anyDown) begin
            seen_r <= seen_r | clean_r;
            if (hcnt_r == 32'(HOLD - 1) && !held_r) begin
                held_r <= 1'b1;
                bothHold <= (seen_r | clean_r) == 2'h3;
            end else if (!held_r) begin
                hcnt_r <= hcnt_r + 32'h1;
            end
        end else begin
            if (!held_r) begin
                stepTap <= seen_r == 2'h1;
                leanTap <= seen_r == 2'h2;
                bothTap <= seen_r == 2'h3;
            end
            seen_r <= 2'h0;
            held_r <= 1'b0;
            hcnt_r <= 32'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            leanHeld <= 1'b0;
        end else begin
            leanHeld <= held_r && anyDown && seen_r == 2'h2;
        end
    end
endmodule : dsm_buttons

// ===== hw/dsm_ctrl.sv
// Purpose: Display mode and scan controller with fuel-entry dialog.
// Assumes: Buttons and flow pulses synchronous to core_clk; registers on a plain port.
// Notes: Long counts are parameters so simulation can shorten them.
// Summary of operation
// - Automatic mode holds each included parameter for the dwell time, four seconds default.
// - Manual mode steps exactly one parameter per step tap, never by itself.
// - Step tap in automatic mode stops the scan and enters manual mode.
// - Manual leaves for automatic on lean tap then step tap, or after five minutes.
// - Scan rate zero keeps the device in manual mode.
// - Both-button tap in manual flips inclusion of shown parameter, display unchanged.
// - Excluded parameter is shown with a leading decimal point.
// - Every power-up marks all parameters included.
// - Manual shows all installed parameters; automatic skips excluded ones.
// - Every second all installed parameters are alarm-checked, excluded or not.
// - Exhaust, head, turbine inlet and oil temperatures cannot be excluded.
// - Primary scan cycles highest head temp, oil and turbine inlet only.
// - With primary variant, timeout is three minutes into primary; step-lean gives full scan.
// - Uninstalled option parameters never appear in any mode.
// - Scan order is fixed from bus voltage through shock cooling.
// - After self-test a fuel prompt shows one second, then no-fuel choice flashes.
// - Lean taps cycle four refuel choices; step tap accepts and enters manual, or enters custom amount entry on custom.
// - Choices: none, main filled, full top, custom; full top absent without aux or tabs.
// - Custom amount: lean hold counts up to full tanks, lean tap counts down.
// - Accepting a refuel clears fuel used unless accumulate is set.
// - Both buttons held five seconds on fuel-used readout in manual mode clears it.
// - One fuel total from flow pulses, no tank split.
// - Press of five seconds or more is a hold, shorter is a tap.
// - Power-up starts in the fuel prompt; manual goes automatic one minute after power-up.
`timescale 1ns/1ps
module dsm_ctrl
    import dsm_pkg::*;
#(
    parameter int TICK = TICK_CYC,
    parameter int DEB = DEB_CYC,
    parameter int HOLD = HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic stepBtn,
    input wire logic leanBtn,
    input wire logic flowPulse,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic [PW-1:0] dispParam,
    output logic dispExcl,
    output logic dispHighHead,
    output logic [5:0] dispMode,
    output logic [1:0] dispChoice,
    output logic dispFlash,
    output logic alarmCheck,
    output logic [NPAR-1:0] alarmSel
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    dsm_state_t st_r, st_nxt;
    dsm_choice_t choice_r;
    logic stepTap, leanTap, bothTap, bothHold, leanHeld;
    logic [7:0] cfg_r;
    logic [NPAR-1:0] inst_r, incl_r, elig;
    logic [PW-1:0] param_r, nxtParam;
    logic found, curOk, advance, restart, scanOff, primVar;
    logic [31:0] freeCnt_r, stCyc_r, fuelUsed_r, fob_r, addAmt_r, limit;
    logic [8:0] secs_r, pwrSecs_r, manLimit;
    logic freeTick, stTick, pwrEvt, manTimeout, dwellDone;
    logic armLean_r, armStep_r, pressed_r, fuelAccept;
    logic [3:0] dwell_r;

    dsm_buttons #(
        .DEB(DEB),
        .HOLD(HOLD)
    ) u_buttons (
        .core_clk(core_clk),
        .reset(reset),
        .stepRaw(stepBtn),
        .leanRaw(leanBtn),
        .stepTap(stepTap),
        .leanTap(leanTap),
        .bothTap(bothTap),
        .bothHold(bothHold),
        .leanHeld(leanHeld)
    );

    dsm_next_param u_next (
        .cur(param_r),
        .elig(elig),
        .nxt(nxtParam),
        .found(found)
    );

    assign scanOff = dwell_r == 4'h0;
    assign primVar = cfg_r[CFG_PRIM];
    assign manLimit = primVar ? MAN_TO_PRIM_S : MAN_TO_S;
    assign freeTick = freeCnt_r == 32'(TICK - 1);
    assign stTick = stCyc_r == 32'(TICK - 1);
    assign pwrEvt = freeTick && pwrSecs_r == POWERUP_S - 9'h1;
    assign manTimeout = stTick && secs_r >= manLimit - 9'h1;
    assign dwellDone = stTick && secs_r == {5'h0, dwell_r} - 9'h1;
    assign limit = (cfg_r[CFG_AUX] ? FULL_TOTAL : FULL_MAIN) - fob_r;

    always_comb begin
        case (st_nxt)
            ST_AUTO: elig = incl_r & inst_r;
            ST_PRIM: elig = PRIM_MASK & inst_r;
            default: elig = inst_r;
        endcase
    end
    assign curOk = elig[param_r];

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_PROMPT: begin
                if (stTick && secs_r == PROMPT_S - 9'h1) begin
                    st_nxt = ST_CHOOSE;
                end
            end
            ST_CHOOSE: begin
                if (stepTap) begin
                    st_nxt = (choice_r == CH_CUSTOM) ? ST_CUSTOM : ST_MANUAL;
                end
            end
            ST_CUSTOM: begin
                if (stepTap) begin
                    st_nxt = ST_MANUAL;
                end
            end
            ST_MANUAL: begin
                if (scanOff) begin
                    st_nxt = ST_MANUAL;
                end else if ((stepTap && armLean_r) || (leanTap && armStep_r && primVar)) begin
                    st_nxt = ST_AUTO;
                end else if (manTimeout) begin
                    st_nxt = primVar ? ST_PRIM : ST_AUTO;
                end else if (pwrEvt) begin
                    st_nxt = ST_AUTO;
                end
            end
            ST_AUTO, ST_PRIM: begin
                if (scanOff || stepTap) begin
                    st_nxt = ST_MANUAL;
                end
            end
            default: st_nxt = ST_MANUAL;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= ST_PROMPT;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        advance = !curOk && found;
        if (st_r == ST_MANUAL && st_nxt == ST_MANUAL && stepTap) begin
            advance = found;
        end
        if ((st_r == ST_AUTO || st_r == ST_PRIM) && st_nxt == st_r && dwellDone) begin
            advance = found;
        end
    end
    assign restart = (st_nxt != st_r) || advance;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            param_r <= P_BUS;
        end else if (advance) begin
            param_r <= nxtParam;
        end
    end

    // Restarting the prescaler keeps every dwell and timeout a whole number of seconds
    always_ff @(posedge core_clk) begin
        if (reset || restart || stTick) begin
            stCyc_r <= 32'h0;
        end else begin
            stCyc_r <= stCyc_r + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || restart) begin
            secs_r <= 9'h0;
        end else if (stTick && secs_r != 9'h1FF) begin
            secs_r <= secs_r + 9'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || freeTick) begin
            freeCnt_r <= 32'h0;
        end else begin
            freeCnt_r <= freeCnt_r + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pwrSecs_r <= 9'h0;
        end else if (freeTick && pwrSecs_r != POWERUP_S) begin
            pwrSecs_r <= pwrSecs_r + 9'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || st_r != ST_MANUAL || bothTap) begin
            armLean_r <= 1'b0;
            armStep_r <= 1'b0;
        end else if (leanTap) begin
            armLean_r <= 1'b1;
            armStep_r <= 1'b0;
        end else if (stepTap) begin
            armLean_r <= 1'b0;
            armStep_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            incl_r <= ALL_MASK;
        end else if (st_r == ST_MANUAL && bothTap && !LOCK_MASK[param_r]) begin
            incl_r[param_r] <= !incl_r[param_r];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            choice_r <= CH_NONE;
        end else if (st_r == ST_CHOOSE && leanTap) begin
            case (choice_r)
                CH_NONE: choice_r <= CH_MAIN;
                CH_MAIN: choice_r <= (cfg_r[CFG_AUX] || cfg_r[CFG_TABS]) ? CH_FULL : CH_CUSTOM;
                CH_FULL: choice_r <= CH_CUSTOM;
                default: choice_r <= CH_NONE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || st_r != ST_CHOOSE) begin
            pressed_r <= 1'b0;
        end else if (stepBtn || leanBtn) begin
            pressed_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || st_r != ST_CUSTOM) begin
            addAmt_r <= 32'h0;
        end else if (leanTap) begin
            addAmt_r <= addAmt_r - ADD_STEP;
        end else if (leanHeld && stTick && $signed(addAmt_r + ADD_STEP) <= $signed(limit)) begin
            addAmt_r <= addAmt_r + ADD_STEP;
        end
    end

    assign fuelAccept = stepTap && (st_r == ST_CUSTOM || (st_r == ST_CHOOSE && choice_r != CH_CUSTOM));

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fob_r <= 32'h0;
        end else if (fuelAccept && choice_r == CH_MAIN) begin
            fob_r <= FULL_MAIN;
        end else if (fuelAccept && choice_r == CH_FULL) begin
            fob_r <= FULL_TOTAL;
        end else if (fuelAccept && choice_r == CH_CUSTOM) begin
            fob_r <= fob_r + addAmt_r - {31'h0, flowPulse};
        end else begin
            fob_r <= fob_r - {31'h0, flowPulse};
        end
    end

    // A pulse in the clearing cycle is still counted
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fuelUsed_r <= 32'h0;
        end else if ((fuelAccept && choice_r != CH_NONE && !cfg_r[CFG_ACC])
                     || (st_r == ST_MANUAL && param_r == P_FUEL && bothHold)) begin
            fuelUsed_r <= {31'h0, flowPulse};
        end else begin
            fuelUsed_r <= fuelUsed_r + {31'h0, flowPulse};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_r <= 8'h00;
            dwell_r <= DWELL_DEF;
            inst_r <= ALL_MASK;
        end else if (regWr && regAddr == CFG_ADDR) begin
            cfg_r <= {regWrData[7:4], 4'h0};
            dwell_r <= regWrData[3:0];
        end else if (regWr && regAddr == OPT_ADDR) begin
            inst_r <= regWrData[NPAR-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || !regRd) begin
            regRdData <= 32'h0;
        end else begin
            case (regAddr)
                CFG_ADDR: regRdData <= {24'h0, cfg_r[7:4], dwell_r};
                OPT_ADDR: regRdData <= {15'h0, inst_r};
                STAT_ADDR: regRdData <= {14'h0, choice_r, 3'h0, param_r, 2'h0, st_r};
                INCL_ADDR: regRdData <= {15'h0, incl_r};
                USED_ADDR: regRdData <= fuelUsed_r;
                FOB_ADDR: regRdData <= fob_r;
                ADD_ADDR: regRdData <= addAmt_r;
                default: regRdData <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dispParam <= P_BUS;
            dispExcl <= 1'b0;
            dispHighHead <= 1'b0;
            dispMode <= ST_PROMPT;
            dispChoice <= CH_NONE;
        end else begin
            dispParam <= param_r;
            dispExcl <= !incl_r[param_r];
            dispHighHead <= st_r == ST_PRIM;
            dispMode <= st_r;
            dispChoice <= choice_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || st_r != ST_CHOOSE || pressed_r) begin
            dispFlash <= 1'b0;
        end else if (freeTick) begin
            dispFlash <= !dispFlash;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            alarmCheck <= 1'b0;
            alarmSel <= {NPAR{1'b0}};
        end else begin
            alarmCheck <= freeTick;
            alarmSel <= inst_r;
        end
    end

    property p_stop;
        st_r == ST_AUTO && stepTap |=> st_r == ST_MANUAL;
    endproperty
    a_stop: assert property (p_stop) else $error("step tap did not stop scan");

    property p_noscan;
        $past(scanOff) |-> st_r != ST_AUTO && st_r != ST_PRIM;
    endproperty
    a_noscan: assert property (p_noscan) else $error("scan entered at rate zero");

    property p_toggle;
        st_r == ST_MANUAL && bothTap && !LOCK_MASK[param_r]
            |=> incl_r[$past(param_r)] != $past(incl_r[param_r]) && $stable(param_r);
    endproperty
    a_toggle: assert property (p_toggle) else $error("inclusion not toggled");

    property p_lock;
        st_r == ST_MANUAL && bothTap && LOCK_MASK[param_r] |=> $stable(incl_r);
    endproperty
    a_lock: assert property (p_lock) else $error("locked parameter excluded");

    property p_manual;
        st_r == ST_MANUAL && $past(st_r) == ST_MANUAL && !$past(stepTap) && $past(curOk)
            |-> param_r == $past(param_r);
    endproperty
    a_manual: assert property (p_manual) else $error("manual mode moved by itself");

    property p_dwell;
        st_r == ST_AUTO && $past(st_r) == ST_AUTO && $changed(param_r)
            |-> $past(secs_r) == {5'h0, dwell_r} - 9'h1 || !$past(curOk);
    endproperty
    a_dwell: assert property (p_dwell) else $error("auto step before dwell");

    property p_prim;
        st_r == ST_PRIM && |(PRIM_MASK & inst_r) |-> PRIM_MASK[param_r];
    endproperty
    a_prim: assert property (p_prim) else $error("primary scan off its three slots");

    property p_used;
        st_r == ST_MANUAL && param_r == P_FUEL && bothHold |=> fuelUsed_r <= 32'h1;
    endproperty
    a_used: assert property (p_used) else $error("fuel used not cleared");

    property p_refuel;
        fuelAccept && choice_r != CH_NONE && !cfg_r[CFG_ACC] |=> fuelUsed_r <= 32'h1 ##1 st_r == ST_MANUAL;
    endproperty
    a_refuel: assert property (p_refuel) else $error("refuel did not clear used");

    c_stop: cover property (st_r == ST_AUTO ##1 st_r == ST_MANUAL);
    c_excl: cover property (st_r == ST_MANUAL && bothTap && !LOCK_MASK[param_r]);
    c_custom: cover property (st_r == ST_CUSTOM ##1 st_r == ST_MANUAL);
    c_prim: cover property (st_r == ST_MANUAL ##1 st_r == ST_PRIM);
endmodule : dsm_ctrl

// ===== verif/dsm_pilot.sv
// Purpose: Pilot model pressing the step and lean buttons.
// Assumes: Buttons are high while pressed.
// Notes: Idle gap after each press lets debounce settle.
`timescale 1ns/1ps
module dsm_pilot (
    input wire logic core_clk,
    output logic stepBtn,
    output logic leanBtn
);
    initial begin
        stepBtn = 1'b0;
        leanBtn = 1'b0;
    end
    task automatic press(input logic s, input logic l, input int len);
        @(posedge core_clk);
        stepBtn <= s;
        leanBtn <= l;
        repeat (len) @(posedge core_clk);
        stepBtn <= 1'b0;
        leanBtn <= 1'b0;
        repeat (12) @(posedge core_clk);
    endtask : press
endmodule : dsm_pilot

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the scan-mode controller.
// Assumes: Shortened counts TICK=20, DEB=2, HOLD=40.
// Notes: Choice cycling runs from a table, the rest by hand.
`timescale 1ns/1ps
module tb_top
    import dsm_pkg::*;
;
    logic core_clk, reset, flowPulse, regWr, regRd, dispExcl, dispHighHead, dispFlash, alarmCheck;
    logic stepBtn, leanBtn;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, rdv;
    logic [PW-1:0] dispParam, p;
    logic [5:0] dispMode;
    logic [1:0] dispChoice;
    logic [NPAR-1:0] alarmSel;
    logic [1:0] chRow [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int nErrors, nCompared, cycles, i;
    dsm_ctrl #(.TICK(20), .DEB(2), .HOLD(40)) i_dsm_ctrl (.core_clk, .reset, .stepBtn, .leanBtn,
        .flowPulse, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .dispParam, .dispExcl,
        .dispHighHead, .dispMode, .dispChoice, .dispFlash, .alarmCheck, .alarmSel);
    dsm_pilot i_dsm_pilot (.core_clk, .stepBtn, .leanBtn);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic finishTest();
        if (nErrors == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finishTest
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            nErrors++;
            finishTest();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        nCompared++;
        if (s !== e) begin
            nErrors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 rdv = regRdData;
    endtask : rd
    function automatic logic [31:0] cur(input int sel);
        return sel == 0 ? {26'h0, dispMode} : sel == 1 ? {27'h0, dispParam} : {31'h0, alarmCheck};
    endfunction : cur
    // Bounded wait for mode (0), slot (1) or alarm pulse (2)
    task automatic waitV(input int sel, input logic [31:0] e, input int lim);
        int k;
        for (k = 0; k < lim && cur(sel) !== e; k++) begin
            @(posedge core_clk);
            #1;
        end
        chk(sel == 0 ? "mode" : sel == 1 ? "param" : "alarm", cur(sel), e);
    endtask : waitV
    initial begin
        {reset, flowPulse, regWr, regRd, regAddr, regWrData} = {1'b1, 43'h0};
        {nErrors, nCompared, cycles} = '0;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        rd(CFG_ADDR);
        chk("cfg", rdv, 32'h00000004);
        rd(INCL_ADDR);
        chk("incl", rdv, {15'h0, ALL_MASK});
        rd(8'h40);
        chk("unmapped", rdv, 32'h0);
        chk("mode", cur(0), ST_PROMPT);
        waitV(0, ST_CHOOSE, 20);
        wr(CFG_ADDR, 32'h00000044);
        for (i = 0; i < 4; i++) begin
            i_dsm_pilot.press(1'b0, 1'b1, 10);
            chk("choice", {30'h0, dispChoice}, {30'h0, chRow[i]});
        end
        i_dsm_pilot.press(1'b1, 1'b0, 10);
        waitV(0, ST_MANUAL, 10);
        p = dispParam;
        i_dsm_pilot.press(1'b1, 1'b0, 10);
        chk("param", cur(1), p + 5'h01);
        repeat (60) @(posedge core_clk);
        chk("param", cur(1), p + 5'h01);
        i_dsm_pilot.press(1'b1, 1'b1, 10);
        chk("param", cur(1), p + 5'h01);
        chk("excl", {31'h0, dispExcl}, 32'h1);
        rd(INCL_ADDR);
        chk("incl", rdv, {15'h0, ALL_MASK} & ~(32'h1 << (p + 5'h01)));
        i_dsm_pilot.press(1'b0, 1'b1, 10);
        i_dsm_pilot.press(1'b1, 1'b0, 10);
        waitV(0, ST_AUTO, 10);
        waitV(1, p + 5'h02, 10);
        repeat (70) @(posedge core_clk);
        chk("param", cur(1), p + 5'h02);
        waitV(1, p + 5'h03, 20);
        i_dsm_pilot.press(1'b1, 1'b0, 10);
        waitV(0, ST_MANUAL, 10);
        wr(CFG_ADDR, 32'h00000040);
        for (i = 0; i < 20 && dispParam !== P_FUEL; i++) i_dsm_pilot.press(1'b1, 1'b0, 10);
        // Pulses first so the clear below has something to clear
        repeat (3) begin
            @(posedge core_clk);
            flowPulse <= 1'b1;
            @(posedge core_clk);
            flowPulse <= 1'b0;
        end
        rd(USED_ADDR);
        chk("used", rdv, 32'h00000003);
        i_dsm_pilot.press(1'b1, 1'b1, 50);
        rd(USED_ADDR);
        chk("used", rdv, 32'h0);
        waitV(2, 32'h1, 25);
        chk("alarmsel", {15'h0, alarmSel}, {15'h0, ALL_MASK});
        repeat (6500) @(posedge core_clk);
        chk("mode", cur(0), ST_MANUAL);
        wr(CFG_ADDR, 32'h00000044);
        waitV(0, ST_AUTO, 6100);
        // Second power-up: flags back, dialog, custom amount, power-up minute, primary scan
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(INCL_ADDR);
        chk("incl", rdv, {15'h0, ALL_MASK});
        chk("mode", cur(0), ST_PROMPT);
        repeat (2) begin
            @(posedge core_clk);
            flowPulse <= 1'b1;
            @(posedge core_clk);
            flowPulse <= 1'b0;
        end
        waitV(0, ST_CHOOSE, 25);
        repeat (25) @(posedge core_clk);
        chk("flash", {31'h0, dispFlash}, 32'h1);
        i_dsm_pilot.press(1'b0, 1'b1, 10);
        i_dsm_pilot.press(1'b0, 1'b1, 10);
        chk("choice", {30'h0, dispChoice}, {30'h0, CH_CUSTOM});
        i_dsm_pilot.press(1'b1, 1'b0, 10);
        waitV(0, ST_CUSTOM, 10);
        i_dsm_pilot.press(1'b0, 1'b1, 10);
        rd(ADD_ADDR);
        chk("add", rdv, 32'h0 - ADD_STEP);
        i_dsm_pilot.press(1'b1, 1'b0, 10);
        rd(USED_ADDR);
        chk("used", rdv, 32'h0);
        rd(FOB_ADDR);
        chk("fob", rdv, 32'h0 - ADD_STEP - 32'h2);
        waitV(0, ST_AUTO, 1300);
        wr(CFG_ADDR, 32'h00000024);
        i_dsm_pilot.press(1'b1, 1'b0, 10);
        waitV(0, ST_PRIM, 3700);
        chk("highhead", {31'h0, dispHighHead}, 32'h1);
        finishTest();
    end
endmodule : tb_top
